// ### hdl/wdtc_osc_tick.sv
`timescale 1ns/1ps
`default_nettype none

`include "wdtc_regs.svh"

module wdtc_osc_tick
   import wdtc_pkg::*;
#(
   parameter int unsigned DIV = 390
)
(
   input wire logic core_clk_i,
   input wire logic rstn_i,
   output logic tick_o
);

   wdtc_div_type d_reg;
   wdtc_div_type d_next;

   // Stands in for the free-running low-rate oscillator
   always_comb
   begin
      d_next = d_reg;
      d_next.tick = 1'b0;
      if (d_reg.cnt >= `WDTC_DIV_W'(DIV - 1))
      begin
         d_next.cnt = '0;
         d_next.tick = 1'b1;
      end
      else
      begin
         d_next.cnt = d_reg.cnt + `WDTC_DIV_W'(1);
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         d_reg <= '0;
      end
      else
      begin
         d_reg <= d_next;
      end
   end

   assign tick_o = d_reg.tick;

endmodule

`default_nettype wire

// ### hdl/wdtc_pkg.sv
`include "wdtc_regs.svh"

package wdtc_pkg;

   typedef enum logic [1:0] {
      WDTC_STOPPED,
      WDTC_IRQ,
      WDTC_RESET,
      WDTC_IRQ_RESET
   } wdtc_mode_type;

   typedef struct packed {
      logic irq_flag;
      logic irq_en;
      logic chg_en;
      logic rst_en;
      logic [3:0] psel;
      logic [2:0] chg_cnt;
      logic [`WDTC_CNT_W-1:0] count;
      logic rst_flag;
      logic rst_pulse;
      logic ack;
      logic [7:0] rdata;
   } wdtc_state_type;

   typedef struct packed {
      logic [`WDTC_DIV_W-1:0] cnt;
      logic tick;
   } wdtc_div_type;

endpackage

// ### hdl/wdtc_regs.svh
`ifndef WDTC_REGS_SVH
`define WDTC_REGS_SVH

// Byte offsets on the register bus
`define WDTC_OFF_CTRL 4'h0
`define WDTC_OFF_STAT 4'h4

// Field positions in watchdog_control
`define WDTC_BIT_IF 7
`define WDTC_BIT_IE 6
`define WDTC_BIT_P3 5
`define WDTC_BIT_CE 4
`define WDTC_BIT_RE 3
`define WDTC_BIT_P2 2
`define WDTC_BIT_P0 0

// Field position in reset_cause_status
`define WDTC_BIT_RF 3

// Timing
`define WDTC_CLK_KHZ 50000
`define WDTC_OSC_KHZ 128
`define WDTC_CHG_CYCLES 3'h4
`define WDTC_BASE_CYCLES 21'h00_0800
`define WDTC_SEL_MAX 4'h9
`define WDTC_CNT_W 21
`define WDTC_DIV_W 16

`endif

// ### hdl/wdtc_top.sv
`timescale 1ns/1ps
`default_nettype none


`include "wdtc_regs.svh"

module wdtc_top
   import wdtc_pkg::*;
#(
   parameter int unsigned CLK_KHZ = `WDTC_CLK_KHZ,
   parameter int unsigned OSC_KHZ = `WDTC_OSC_KHZ
)
(
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   input wire logic wdr_i,
   input wire logic irq_ack_i,
   input wire logic global_irq_en_i,
   input wire logic always_on_fuse_i,
   input wire logic clock_monitor_i,
   output logic irq_o,
   output logic sys_reset_o,
   output logic timeout_reset_flag_o
);

   // Oscillator period in system clocks, rounded down
   localparam int unsigned OSC_DIV = CLK_KHZ / OSC_KHZ;

   wdtc_state_type s_reg;
   wdtc_state_type s_next;
   wdtc_mode_type mode;
   logic osc_tick;
   logic req;
   logic done;
   logic wr_ctrl;
   logic wr_stat;
   logic timeout;
   logic [`WDTC_CNT_W-1:0] limit;
   logic [7:0] rd;
   logic [7:0] wd;

   // Terminal count for a prescaler code
   function automatic logic [`WDTC_CNT_W-1:0] limit_of(input logic [3:0] sel);
      logic [3:0] s;
      // Reserved codes behave as the longest period
      s = (sel > `WDTC_SEL_MAX) ? `WDTC_SEL_MAX : sel;
      limit_of = (`WDTC_BASE_CYCLES << s) - `WDTC_CNT_W'(1);
   endfunction

   function automatic wdtc_mode_type mode_of(
      input logic fuse,
      input logic mon,
      input logic re,
      input logic ie
   );
      logic active;
      active = fuse | re | ie;
      if (mon && active)
      begin
         mode_of = WDTC_RESET;
      end
      else if (fuse)
      begin
         mode_of = WDTC_RESET;
      end
      else
      begin
         case ({re, ie})
            2'b01: mode_of = WDTC_IRQ;
            2'b10: mode_of = WDTC_RESET;
            2'b11: mode_of = WDTC_IRQ_RESET;
            default: mode_of = WDTC_STOPPED;
         endcase
      end
   endfunction

   wdtc_osc_tick #(
      .DIV(OSC_DIV)
   ) u_osc (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .tick_o(osc_tick)
   );

   // Clock monitor forces reset mode only while fuse, reset enable or interrupt enable is set
   assign mode = mode_of(always_on_fuse_i, clock_monitor_i, s_reg.rst_en, s_reg.irq_en);
   assign limit = limit_of(s_reg.psel);

   // Every access takes two cycles: one wait, then completion
   assign req = avs_read_i | avs_write_i;
   assign done = req & s_reg.ack;
   assign avs_waitrequest_o = req & ~s_reg.ack;
   assign wd = avs_writedata_i[7:0];
   assign wr_ctrl = done & avs_write_i & avs_byteenable_i[0] & (avs_address_i == `WDTC_OFF_CTRL);
   assign wr_stat = done & avs_write_i & avs_byteenable_i[0] & (avs_address_i == `WDTC_OFF_STAT);

   // Greater-or-equal so a shorter period still expires
   assign timeout = osc_tick & (mode != WDTC_STOPPED) & ~wdr_i & (s_reg.count >= limit);

   always_comb
   begin
      rd = 8'h00;
      case (avs_address_i)
         `WDTC_OFF_CTRL:
         begin
            rd[`WDTC_BIT_IF] = s_reg.irq_flag;
            rd[`WDTC_BIT_IE] = s_reg.irq_en;
            rd[`WDTC_BIT_P3] = s_reg.psel[3];
            rd[`WDTC_BIT_CE] = s_reg.chg_en;
            rd[`WDTC_BIT_RE] = s_reg.rst_en;
            rd[`WDTC_BIT_P2:`WDTC_BIT_P0] = s_reg.psel[2:0];
         end
         `WDTC_OFF_STAT:
         begin
            rd[`WDTC_BIT_RF] = s_reg.rst_flag;
         end
         default:
         begin
            rd = 8'h00;
         end
      endcase
   end

   always_comb
   begin
      s_next = s_reg;
      s_next.rst_pulse = 1'b0;

      // Bus handshake; read data captured in the wait cycle
      s_next.ack = req & ~s_reg.ack;
      if (req && !s_reg.ack)
      begin
         s_next.rdata = rd;
      end

      // Change window runs down in system clocks
      if (s_reg.chg_en)
      begin
         if (s_reg.chg_cnt == 3'h0)
         begin
            s_next.chg_en = 1'b0;
         end
         else
         begin
            s_next.chg_cnt = s_reg.chg_cnt - 3'h1;
         end
      end

      if (wr_ctrl)
      begin
         if (wd[`WDTC_BIT_IF])
         begin
            s_next.irq_flag = 1'b0;
         end
         s_next.irq_en = wd[`WDTC_BIT_IE];
         if (s_reg.chg_en)
         begin
            // One protected write closes the window
            s_next.rst_en = wd[`WDTC_BIT_RE];
            s_next.psel = {wd[`WDTC_BIT_P3], wd[`WDTC_BIT_P2:`WDTC_BIT_P0]};
            s_next.chg_en = 1'b0;
         end
         else
         begin
            // Outside the window reset enable may only be raised
            if (wd[`WDTC_BIT_RE])
            begin
               s_next.rst_en = 1'b1;
            end
            if (wd[`WDTC_BIT_CE])
            begin
               s_next.chg_en = 1'b1;
               s_next.chg_cnt = `WDTC_CHG_CYCLES - 3'h1;
            end
         end
      end

      if (wr_stat && !wd[`WDTC_BIT_RF])
      begin
         s_next.rst_flag = 1'b0;
      end

      if (irq_ack_i)
      begin
         s_next.irq_flag = 1'b0;
         if (mode == WDTC_IRQ_RESET)
         begin
            s_next.irq_en = 1'b0;
         end
      end

      if (wdr_i || mode == WDTC_STOPPED)
      begin
         s_next.count = '0;
      end
      else if (osc_tick)
      begin
         if (timeout)
         begin
            s_next.count = '0;
         end
         else
         begin
            s_next.count = s_reg.count + `WDTC_CNT_W'(1);
         end
      end

      if (timeout)
      begin
         case (mode)
            WDTC_IRQ:
            begin
               s_next.irq_flag = 1'b1;
            end
            WDTC_IRQ_RESET:
            begin
               // A handler entered this cycle counts as serviced
               if (s_next.irq_flag)
               begin
                  s_next.rst_pulse = 1'b1;
               end
               else
               begin
                  s_next.irq_flag = 1'b1;
               end
            end
            WDTC_RESET:
            begin
               s_next.rst_pulse = 1'b1;
            end
            default:
            begin
               s_next.rst_pulse = 1'b0;
            end
         endcase
      end

      // The system reset returns control to defaults
      if (s_next.rst_pulse)
      begin
         s_next.irq_flag = 1'b0;
         s_next.irq_en = 1'b0;
         s_next.chg_en = 1'b0;
         s_next.chg_cnt = 3'h0;
         s_next.rst_en = 1'b0;
         s_next.psel = 4'h0;
         s_next.count = '0;
         s_next.rst_flag = 1'b1;
      end

      // Forcing last so no write can undo it
      if (s_next.rst_flag)
      begin
         s_next.rst_en = 1'b1;
      end
      if (always_on_fuse_i)
      begin
         s_next.rst_en = 1'b1;
         s_next.irq_en = 1'b0;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (!rstn_i)
      begin
         s_reg <= '0;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign avs_readdata_o = {24'h00_0000, s_reg.rdata};

   // Clock-monitor mode must not raise interrupts
   assign irq_o = s_reg.irq_flag & s_reg.irq_en & global_irq_en_i
                  & ((mode == WDTC_IRQ) | (mode == WDTC_IRQ_RESET));

   assign sys_reset_o = s_reg.rst_pulse;
   assign timeout_reset_flag_o = s_reg.rst_flag;

endmodule

`default_nettype wire

// ### verification/test_watchdog_timer_control.sv
`timescale 1ns/1ps
`default_nettype none

`include "wdtc_regs.svh"

`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; $display("ERROR %0t got %h exp %h", $time, g, e); end end

module test_watchdog_timer_control;
   import wdtc_pkg::*;
   logic core_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic [3:0] adr = 4'h0;
   logic rd_s = 1'b0;
   logic wr_s = 1'b0;
   logic [31:0] wd = 32'h0000_0000;
   logic [3:0] be = 4'h1;
   logic [31:0] rdata;
   logic wait_s;
   logic wdr_i = 1'b0;
   logic ack = 1'b0;
   logic gie = 1'b1;
   logic fuse = 1'b0;
   logic mon = 1'b0;
   logic irq_o;
   logic sys_reset_o;
   logic rflag;
   int num_errors = 0;
   int checks_done = 0;

   always #10 core_clk_i = ~core_clk_i;

   wdtc_top #(.OSC_KHZ(12500)) uut (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .avs_address_i(adr),
      .avs_read_i(rd_s),
      .avs_write_i(wr_s),
      .avs_writedata_i(wd),
      .avs_byteenable_i(be),
      .avs_readdata_o(rdata),
      .avs_waitrequest_o(wait_s),
      .wdr_i(wdr_i),
      .irq_ack_i(ack),
      .global_irq_en_i(gie),
      .always_on_fuse_i(fuse),
      .clock_monitor_i(mon),
      .irq_o(irq_o),
      .sys_reset_o(sys_reset_o),
      .timeout_reset_flag_o(rflag)
   );

   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      adr <= a;
      wr_s <= w;
      rd_s <= !w;
      wd <= {24'h00_0000, d};
      // Waitrequest is combinational: look at it settled, mid-cycle
      do
      begin
         @(negedge core_clk_i);
         n++;
      end while (wait_s !== 1'b0 && n < 50);
      @(posedge core_clk_i);
      q = rdata[7:0];
      wr_s <= 1'b0;
      rd_s <= 1'b0;
      if (n >= 50)
      begin
         num_errors++;
         $display("ERROR %0t bus hang", $time);
         close_out();
      end
      @(posedge core_clk_i);
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(a, 1'b1, d, q);
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      logic [7:0] q;
      bus(a, 1'b0, 8'h00, q);
      `CHK(q, e)
   endtask

   // Waits for the interrupt or the reset pulse
   task automatic wait_for(input bit rst);
      int n;
      n = 0;
      // Reset pulse lasts one cycle, so sample it settled
      do
      begin
         @(negedge core_clk_i);
         n++;
      end while (((rst ? sys_reset_o : irq_o) !== 1'b1) && n < 20000);
      @(posedge core_clk_i);
      if (n >= 20000)
      begin
         num_errors++;
         $display("ERROR %0t no time-out", $time);
         close_out();
      end
   endtask

   initial
   begin
      repeat (10) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      @(posedge core_clk_i);
      rd(`WDTC_OFF_CTRL, 8'h00);
      rd(`WDTC_OFF_STAT, 8'h00);
      rd(4'h8, 8'h00);
      $display("test reset done");
      wr(`WDTC_OFF_CTRL, 8'h27);
      rd(`WDTC_OFF_CTRL, 8'h00);
      wr(`WDTC_OFF_CTRL, 8'h08);
      wr(`WDTC_OFF_CTRL, 8'h00);
      rd(`WDTC_OFF_CTRL, 8'h08);
      wdr_i <= 1'b1;
      @(posedge core_clk_i);
      wdr_i <= 1'b0;
      wr(`WDTC_OFF_CTRL, 8'h18);
      wr(`WDTC_OFF_CTRL, 8'h0F);
      rd(`WDTC_OFF_CTRL, 8'h0F);
      wr(`WDTC_OFF_CTRL, 8'h1F);
      rd(`WDTC_OFF_CTRL, 8'h1F);
      repeat (4) @(posedge core_clk_i);
      rd(`WDTC_OFF_CTRL, 8'h0F);
      wr(`WDTC_OFF_CTRL, 8'h1F);
      wr(`WDTC_OFF_CTRL, 8'h00);
      rd(`WDTC_OFF_CTRL, 8'h00);
      $display("test change window done");
      wr(`WDTC_OFF_CTRL, 8'h40);
      wait_for(1'b0);
      rd(`WDTC_OFF_CTRL, 8'hC0);
      gie <= 1'b0;
      @(posedge core_clk_i);
      @(posedge core_clk_i);
      `CHK(irq_o, 1'b0)
      gie <= 1'b1;
      @(posedge core_clk_i);
      @(posedge core_clk_i);
      `CHK(irq_o, 1'b1)
      wr(`WDTC_OFF_CTRL, 8'hC0);
      rd(`WDTC_OFF_CTRL, 8'h40);
      $display("test irq mode done");
      wdr_i <= 1'b1;
      @(posedge core_clk_i);
      wdr_i <= 1'b0;
      wr(`WDTC_OFF_CTRL, 8'h48);
      wait_for(1'b0);
      rd(`WDTC_OFF_CTRL, 8'hC8);
      ack <= 1'b1;
      @(posedge core_clk_i);
      ack <= 1'b0;
      @(posedge core_clk_i);
      rd(`WDTC_OFF_CTRL, 8'h08);
      wait_for(1'b1);
      @(posedge core_clk_i);
      rd(`WDTC_OFF_STAT, 8'h08);
      rd(`WDTC_OFF_CTRL, 8'h08);
      wr(`WDTC_OFF_CTRL, 8'h18);
      wr(`WDTC_OFF_CTRL, 8'h00);
      rd(`WDTC_OFF_CTRL, 8'h08);
      wr(`WDTC_OFF_STAT, 8'h00);
      wr(`WDTC_OFF_CTRL, 8'h18);
      wr(`WDTC_OFF_CTRL, 8'h00);
      rd(`WDTC_OFF_CTRL, 8'h00);
      rd(`WDTC_OFF_STAT, 8'h00);
      wr(`WDTC_OFF_CTRL, 8'h48);
      wait_for(1'b0);
      rd(`WDTC_OFF_CTRL, 8'hC8);
      wait_for(1'b1);
      @(posedge core_clk_i);
      rd(`WDTC_OFF_STAT, 8'h08);
      $display("test combined mode done");
      fuse <= 1'b1;
      mon <= 1'b1;
      @(posedge core_clk_i);
      rd(`WDTC_OFF_CTRL, 8'h08);
      wr(`WDTC_OFF_CTRL, 8'h40);
      rd(`WDTC_OFF_CTRL, 8'h08);
      $display("test fuse done");
      close_out();
   end
endmodule

`default_nettype wire

// ### verification/wdtc_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module wdtc_asserts (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic irq_ack_i,
   input wire logic global_irq_en_i,
   input wire logic always_on_fuse_i,
   input wire logic clock_monitor_i,
   input wire logic irq_o,
   input wire logic sys_reset_o,
   input wire logic timeout_reset_flag_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);

   sequence s_req;
      (avs_read_i || avs_write_i) && avs_waitrequest_o;
   endsequence
   sequence s_done;
      !avs_waitrequest_o;
   endsequence

   AST_ONE_WAIT: assert property (s_req |=> s_done) else $error("bus wait not one cycle");
   AST_IDLE_NO_WAIT: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
      else $error("wait while idle");
   AST_RD_UPPER: assert property (avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h00_0000)
      else $error("upper read bits set");
   AST_RST_PULSE: assert property (sys_reset_o |=> !sys_reset_o [*8]) else $error("reset pulse long");
   AST_RST_FLAG: assert property (sys_reset_o |=> timeout_reset_flag_o) else $error("reset flag not set");
   AST_IRQ_GLOBAL: assert property (irq_o |-> global_irq_en_i) else $error("irq without global enable");
   AST_FUSE_NO_IRQ: assert property (always_on_fuse_i && $past(always_on_fuse_i) |-> !irq_o)
      else $error("irq under fuse");
   AST_MON_NO_IRQ: assert property (clock_monitor_i |-> !irq_o) else $error("irq under monitor");
   AST_ACK_CLEARS: assert property (irq_ack_i |=> !irq_o) else $error("ack left irq");
endmodule

bind wdtc_top wdtc_asserts chk (
   .core_clk_i(core_clk_i),
   .rstn_i(rstn_i),
   .avs_read_i(avs_read_i),
   .avs_write_i(avs_write_i),
   .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o),
   .irq_ack_i(irq_ack_i),
   .global_irq_en_i(global_irq_en_i),
   .always_on_fuse_i(always_on_fuse_i),
   .clock_monitor_i(clock_monitor_i),
   .irq_o(irq_o),
   .sys_reset_o(sys_reset_o),
   .timeout_reset_flag_o(timeout_reset_flag_o)
);

`default_nettype wire
